// File: design/qdx_map.vh
// constants for the three-axis quadrature decoder
`ifndef QDX_MAP_VH
`define QDX_MAP_VH
`define QDX_AXES 3
`define QDX_CNT_W 16
`define QDX_CNT_RST 16'h0000
`define QDX_CNT_ONE 16'h0001
`define QDX_DIV_ONE 8'h01
`define QDX_PH_RST 2'h0
`define QDX_DIR_NONE 2'h0
`define QDX_DIR_UP 2'h1
`define QDX_DIR_DN 2'h2
`define QDX_AX_X 0
`define QDX_AX_Y 1
`define QDX_AX_Z 2
`define QDX_PORT0_W 8
`define QDX_PORT1_W 6
`define QDX_SEL_W 3
`define QDX_DIV_W 8
`define QDX_DIV_RST 8'h00
`define QDX_CLK_MHZ 200
`define QDX_SMP_MAX_MHZ 16
`define QDX_DIV_MIN ((`QDX_CLK_MHZ + `QDX_SMP_MAX_MHZ - 1) / `QDX_SMP_MAX_MHZ - 1)
`define QDX_FLT_LEN 3
`define QDX_FLT_W 2
`define QDX_FLT_ONES 3'h7
`define QDX_FLT_ZERO 3'h0
`endif

// File: design/qdx_filter.v
// spike filter for one channel input
`timescale 1ns/1ps
`default_nettype none
`include "qdx_map.vh"
module qdx_filter (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_smp,
  input wire i_raw,
  output wire o_clean
);
  reg [`QDX_FLT_LEN-1:0] hist_q;
  reg clean_q;
  // output moves only after the level has held for all taps
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hist_q <= `QDX_FLT_ZERO;
      clean_q <= 1'b0;
    end else if (i_smp) begin
      hist_q <= {hist_q[`QDX_FLT_LEN-2:0], i_raw};
      if (hist_q == `QDX_FLT_ONES)
        clean_q <= 1'b1;
      else if (hist_q == `QDX_FLT_ZERO)
        clean_q <= 1'b0;
    end
  end
  assign o_clean = clean_q;
endmodule
`default_nettype wire

// File: design/qdx_decoder.v
// three-axis quadrature decoder with sampling divider and wake request
`timescale 1ns/1ps
`default_nettype none
`include "qdx_map.vh"
module qdx_decoder (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [`QDX_PORT0_W-1:0] i_port_zero,
  input wire [`QDX_PORT1_W-1:0] i_port_one,
  input wire [`QDX_AXES-1:0] i_src_port_one,
  input wire [`QDX_AXES*`QDX_SEL_W-1:0] i_sel_a,
  input wire [`QDX_AXES*`QDX_SEL_W-1:0] i_sel_b,
  input wire [`QDX_DIV_W-1:0] i_clk_div,
  input wire i_enable,
  input wire i_wake_en,
  input wire i_wake_clr,
  output wire [`QDX_CNT_W-1:0] o_count_x,
  output wire [`QDX_CNT_W-1:0] o_count_y,
  output wire [`QDX_CNT_W-1:0] o_count_z,
  output wire o_wake
);
  // pick one pin of the chosen port; port one is narrower, high indices read 0
  function pick;
    input from_one;
    input [`QDX_SEL_W-1:0] sel;
    input [`QDX_PORT0_W-1:0] p0;
    input [`QDX_PORT1_W-1:0] p1;
    begin
      if (from_one)
        pick = (sel < `QDX_PORT1_W) ? p1[sel] : 1'b0;
      else
        pick = p0[sel];
    end
  endfunction

  // step direction from old and new phase pair {a, b}; a leading b counts up
  function [1:0] step;
    input [1:0] prev;
    input [1:0] cur;
    begin
      case ({prev, cur})
        4'h2, 4'hb, 4'hd, 4'h4: step = `QDX_DIR_UP;
        4'h1, 4'h7, 4'he, 4'h8: step = `QDX_DIR_DN;
        default: step = `QDX_DIR_NONE;
      endcase
    end
  endfunction

  // next count of one axis; plain add and subtract wrap in two's complement
  function [`QDX_CNT_W-1:0] bump;
    input [`QDX_CNT_W-1:0] cnt;
    input [1:0] dir;
    begin
      case (dir)
        `QDX_DIR_UP: bump = cnt + `QDX_CNT_ONE;
        `QDX_DIR_DN: bump = cnt - `QDX_CNT_ONE;
        default: bump = cnt;
      endcase
    end
  endfunction

  // sample tick; divider floored so the rate never exceeds 16 MHz
  localparam [`QDX_DIV_W-1:0] DIV_FLOOR = `QDX_DIV_MIN;
  reg [`QDX_DIV_W-1:0] div_q;
  wire [`QDX_DIV_W-1:0] div_lim = (i_clk_div < DIV_FLOOR) ?
    DIV_FLOOR : i_clk_div;
  wire smp = i_enable && (div_q == `QDX_DIV_RST);
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      div_q <= `QDX_DIV_RST;
    else if (!i_enable || div_q == `QDX_DIV_RST)
      div_q <= div_lim;
    else
      div_q <= div_q - `QDX_DIV_ONE;
  end

  reg wake_q;

  // axis x: pin pick, two filters, phase memory and count
  wire x_ra = pick(i_src_port_one[`QDX_AX_X], i_sel_a[`QDX_AX_X*`QDX_SEL_W +: `QDX_SEL_W],
    i_port_zero, i_port_one);
  wire x_rb = pick(i_src_port_one[`QDX_AX_X], i_sel_b[`QDX_AX_X*`QDX_SEL_W +: `QDX_SEL_W],
    i_port_zero, i_port_one);
  wire x_ca;
  wire x_cb;
  reg [`QDX_CNT_W-1:0] x_cnt_q;
  reg [1:0] x_ph_q;

  qdx_filter u_x_fa (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_smp(smp),
    .i_raw(x_ra),
    .o_clean(x_ca)
  );
  qdx_filter u_x_fb (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_smp(smp),
    .i_raw(x_rb),
    .o_clean(x_cb)
  );

  wire [1:0] x_dir = step(x_ph_q, {x_ca, x_cb});
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      x_cnt_q <= `QDX_CNT_RST;
      x_ph_q <= `QDX_PH_RST;
    end else if (smp) begin
      x_ph_q <= {x_ca, x_cb};
      x_cnt_q <= bump(x_cnt_q, x_dir);
    end
  end

  // axis y: same path, own pins and count
  wire y_ra = pick(i_src_port_one[`QDX_AX_Y], i_sel_a[`QDX_AX_Y*`QDX_SEL_W +: `QDX_SEL_W],
    i_port_zero, i_port_one);
  wire y_rb = pick(i_src_port_one[`QDX_AX_Y], i_sel_b[`QDX_AX_Y*`QDX_SEL_W +: `QDX_SEL_W],
    i_port_zero, i_port_one);
  wire y_ca;
  wire y_cb;
  reg [`QDX_CNT_W-1:0] y_cnt_q;
  reg [1:0] y_ph_q;

  qdx_filter u_y_fa (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_smp(smp),
    .i_raw(y_ra),
    .o_clean(y_ca)
  );
  qdx_filter u_y_fb (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_smp(smp),
    .i_raw(y_rb),
    .o_clean(y_cb)
  );

  wire [1:0] y_dir = step(y_ph_q, {y_ca, y_cb});
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      y_cnt_q <= `QDX_CNT_RST;
      y_ph_q <= `QDX_PH_RST;
    end else if (smp) begin
      y_ph_q <= {y_ca, y_cb};
      y_cnt_q <= bump(y_cnt_q, y_dir);
    end
  end

  // axis z: same path, own pins and count
  wire z_ra = pick(i_src_port_one[`QDX_AX_Z], i_sel_a[`QDX_AX_Z*`QDX_SEL_W +: `QDX_SEL_W],
    i_port_zero, i_port_one);
  wire z_rb = pick(i_src_port_one[`QDX_AX_Z], i_sel_b[`QDX_AX_Z*`QDX_SEL_W +: `QDX_SEL_W],
    i_port_zero, i_port_one);
  wire z_ca;
  wire z_cb;
  reg [`QDX_CNT_W-1:0] z_cnt_q;
  reg [1:0] z_ph_q;

  qdx_filter u_z_fa (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_smp(smp),
    .i_raw(z_ra),
    .o_clean(z_ca)
  );
  qdx_filter u_z_fb (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_smp(smp),
    .i_raw(z_rb),
    .o_clean(z_cb)
  );

  wire [1:0] z_dir = step(z_ph_q, {z_ca, z_cb});
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      z_cnt_q <= `QDX_CNT_RST;
      z_ph_q <= `QDX_PH_RST;
    end else if (smp) begin
      z_ph_q <= {z_ca, z_cb};
      z_cnt_q <= bump(z_cnt_q, z_dir);
    end
  end

  // any valid step on any axis; a double change steps nothing, so no wake
  wire moved_any = smp && ((x_dir != `QDX_DIR_NONE) || (y_dir != `QDX_DIR_NONE) ||
    (z_dir != `QDX_DIR_NONE));

  // sticky wake; a new movement wins over a clear in the same cycle
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      wake_q <= 1'b0;
    else if (i_wake_en && moved_any)
      wake_q <= 1'b1;
    else if (i_wake_clr || !i_wake_en)
      wake_q <= 1'b0;
  end

  assign o_count_x = x_cnt_q;
  assign o_count_y = y_cnt_q;
  assign o_count_z = z_cnt_q;
  assign o_wake = wake_q;
endmodule
`default_nettype wire

// File: test/qdx_enc.sv
// encoder model driving the two phases
`timescale 1ns/1ps
`default_nettype none
module qdx_enc (
  input wire logic i_clk,
  input wire logic [2:0] i_cmd,
  output logic [1:0] o_ab
);
  // cmd: bit2 flip both, bit1 step, bit0 up
  initial o_ab = 2'h0;
  always @(posedge i_clk)
    if (i_cmd[2]) o_ab <= ~o_ab;
    else if (i_cmd[1]) o_ab <= i_cmd[0] ? {~o_ab[0], o_ab[1]} : {o_ab[0], ~o_ab[1]};
endmodule
`default_nettype wire

// File: test/qdx_chk_sva.sv
// checks on decoder ports
`timescale 1ns/1ps
`default_nettype none
module qdx_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_wake_en,
  input wire logic i_wake_clr,
  input wire logic [15:0] o_count_x,
  input wire logic o_wake
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_idle; $stable(o_count_x)[*8]; endsequence
  chk_step_one: assert property ($changed(o_count_x) |->
    o_count_x - $past(o_count_x) inside {16'h0001, 16'hffff}) else $error("step");
  chk_tick_gap: assert property ($changed(o_count_x) |=> s_idle) else $error("gap");
  chk_wake_set: assert property ($changed(o_count_x) && i_wake_en |-> ##[0:2] o_wake)
    else $error("set");
  chk_wake_hold: assert property (o_wake && i_wake_en && !i_wake_clr |=> o_wake)
    else $error("hold");
  chk_wake_off: assert property (!i_wake_en |=> !o_wake) else $error("en");
  chk_wake_rise: assert property ($rose(o_wake) |-> $past(i_wake_en)) else $error("rise");
  chk_wake_clr: assert property (i_wake_clr && $stable(o_count_x) |=> !o_wake)
    else $error("clr");
  chk_reset_zero: assert property ($rose(i_rst_b) |-> o_count_x == 16'h0000 && !o_wake)
    else $error("rst");
endmodule
`default_nettype wire

// File: test/tb_quadrature_decoder_xyz.sv
// decoder bench
`timescale 1ns/1ps
`default_nettype none
module tb_quadrature_decoder_xyz;
  logic clk = 0, rst_b = 0, en = 0, wen = 1, clr = 0, wk;
  logic [2:0] cmd = 3'h0;
  logic [1:0] ab;
  logic [15:0] cx, cy, cz;
  int bad_count = 0, n_checks = 0;
  initial forever #2.5 clk = ~clk;
  qdx_enc enc (.i_clk(clk), .i_cmd(cmd), .o_ab(ab));
  qdx_decoder dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_port_zero({4{ab}}),
    .i_port_one({3{ab}}), .i_src_port_one(3'h2), .i_sel_a(9'h009), .i_sel_b(9'h040),
    .i_clk_div(8'h00), .i_enable(en), .i_wake_en(wen), .i_wake_clr(clr),
    .o_count_x(cx), .o_count_y(cy), .o_count_z(cz), .o_wake(wk));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // gap covers filter plus count latency at the capped rate
  task automatic go(input logic [2:0] c, input int n, input logic [16:0] e);
    cmd = c;
    tick(n);
    cmd = 3'h0;
    tick(100);
    n_checks++;
    if ({wk, cx, cy, cz} !== {e, e[15:0], -e[15:0]}) begin
      bad_count++;
      $display("[ERR] %0t counts", $time);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(12);
    {rst_b, en} = 2'h3;
    go(3'h4, 2, 17'h0_0000);
    for (int i = 1; i <= 5; i++) go(3'h3, 1, {1'b1, 16'(i)});
    for (int i = 4; i >= -2; i--) go(3'h2, 1, {1'b1, 16'(i)});
    go(3'h4, 1, 17'h1_fffe);
    clr = 1;
    go(3'h4, 2, 17'h0_fffe);
    {clr, en} = 2'h0;
    go(3'h3, 1, 17'h0_fffe);
    en = 1;
    go(3'h0, 1, 17'h1_ffff);
    wen = 0;
    go(3'h3, 1, 17'h0_0000);
    wrap_up;
  end
endmodule
bind qdx_decoder qdx_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_wake_en(i_wake_en),
  .i_wake_clr(i_wake_clr), .o_count_x(o_count_x), .o_wake(o_wake));
`default_nettype wire
